// ==== rtl/backlight_fade_pkg.sv ====
// Constants shared by the backlight fade and peak current block.
package backlight_fade_pkg;
    // Register offsets on the serial register port.
    localparam logic [7:0] FADE_RATES_OFFSET = 8'h08;
    localparam logic [7:0] PEAK_CURRENT_OFFSET = 8'h09;
    // Field positions.
    localparam int RISE_RATE_LSB = 0;
    localparam int DECAY_RATE_LSB = 4;
    localparam int RATE_WIDTH = 4;
    localparam int PEAK_CODE_WIDTH = 7;
    // Reset values.
    localparam logic [7:0] FADE_RATES_RESET = 8'h00;
    localparam logic [6:0] PEAK_CODE_RESET = 7'h00;
    // Rate code where timed fading is off and the fast ramp applies.
    localparam logic [3:0] RATE_DISABLED = 4'h0;
    // First code of the coarse half-second steps.
    localparam logic [3:0] RATE_COARSE_FIRST = 4'hb;
    // Timing.
    localparam int CLK_PERIOD_NS = 5;
    localparam int FADE_UNIT_NS = 100_000_000;
    localparam int FULL_SCALE_STEPS = 127;
    localparam int FADE_UNIT_CYCLES =
        FADE_UNIT_NS / CLK_PERIOD_NS / FULL_SCALE_STEPS;
    // Current scale in microamperes.
    localparam int FULL_SCALE_UA = 30000;
    localparam logic [6:0] TOP_CODE = 7'h7f;
endpackage : backlight_fade_pkg

// ==== rtl/backlight_fade_and_peak_current.sv ====
// Backlight fade-rate and peak-current registers with the current ramp.
`timescale 1ns/1ps

// Overview of operation
// - Rise rate zero: no timed fade, reach new current within about 100 ms.
// - Nonzero rise rate: ramp current up to peak when backlight turns on.
// - Each rate code is the time of a full 0 to 30 mA transition.
// - Shorter distances between currents take proportionally less time.
// - Rate codes: 0.3 s steps up to 3.0 s, then 0.5 s steps to 5.5 s.
// - Fading disabled still ramps quickly, finishing in about 100 ms.
// - Peak current code sits in bits 6 to 0; bit 7 is reserved.
// - Code maps linear or square; zero gives zero, top code gives 30 mA.
// - Decay rate in bits 7 to 4, same encoding, zero disables timed fade.
// - The linear or square mapping holds only when law select is zero.
module backlight_fade_and_peak_current
    import backlight_fade_pkg::*;
#(
    parameter int unsigned FADE_UNIT_CYCLES_P = FADE_UNIT_CYCLES
)
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_N,
    // Register port from the serial interface.
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // Backlight control.
    input wire logic BL_ON,
    input wire logic LAW_SELECT,
    input wire logic SQUARE_LAW,
    // Current sink drive and status.
    output logic [6:0] CUR_CODE,
    output logic [14:0] CURRENT_UA,
    output logic LAW_VALID,
    output logic RAMP_BUSY
);

    typedef struct packed {
        logic [7:0] fade_rates;
        logic [6:0] peak;
        logic [6:0] code;
        logic [31:0] cnt;
        logic [7:0] rdata;
        logic [14:0] current;
        logic law_valid;
    } state_type;

    state_type st_q;
    state_type st_d;
    logic [6:0] target;
    logic [3:0] rise_rate;
    logic [3:0] decay_rate;

    // Fade time of a rate code in tenths of a second.
    function automatic logic [5:0] rate_tenths(input logic [3:0] rate);
        logic [5:0] t;
        t = 6'h00;
        if (rate == RATE_DISABLED)
            t = 6'h01;
        else if (rate < RATE_COARSE_FIRST)
            t = 6'(3 * rate);
        else
            t = 6'(30 + 5 * (rate - 4'ha));
        return t;
    endfunction : rate_tenths

    // Cycles between two code steps for a rate code.
    function automatic logic [31:0] step_cycles(input logic [3:0] rate);
        return 32'(rate_tenths(rate) * FADE_UNIT_CYCLES_P);
    endfunction : step_cycles

    // Current in microamperes for a code under the chosen law.
    function automatic logic [14:0] code_to_ua(input logic [6:0] c,
                                               input logic sq);
        logic [31:0] p;
        p = 32'h0;
        if (sq)
            p = 32'(c) * 32'(c) * 32'(FULL_SCALE_UA)
                / 32'(FULL_SCALE_STEPS * FULL_SCALE_STEPS);
        else
            p = 32'(c) * 32'(FULL_SCALE_UA) / 32'(FULL_SCALE_STEPS);
        return p[14:0];
    endfunction : code_to_ua

    assign rise_rate = st_q.fade_rates[RISE_RATE_LSB +: RATE_WIDTH];
    assign decay_rate = st_q.fade_rates[DECAY_RATE_LSB +: RATE_WIDTH];
    assign target = BL_ON ? st_q.peak : 7'h00;

    always_comb
    begin
        st_d = st_q;
        if (REG_WR && REG_ADDR == FADE_RATES_OFFSET)
            st_d.fade_rates = REG_WDATA;
        if (REG_WR && REG_ADDR == PEAK_CURRENT_OFFSET)
            st_d.peak = REG_WDATA[PEAK_CODE_WIDTH-1:0];
        if (REG_RD)
        begin
            unique case (REG_ADDR)
                FADE_RATES_OFFSET: st_d.rdata = st_q.fade_rates;
                PEAK_CURRENT_OFFSET: st_d.rdata = {1'b0, st_q.peak};
                default: st_d.rdata = 8'h00;
            endcase
        end
        // One code step per interval; a shorter span needs fewer steps.
        if (st_q.cnt == 32'h0 && st_q.code != target)
        begin
            if (st_q.code < target)
            begin
                st_d.code = st_q.code + 7'h01;
                st_d.cnt = step_cycles(rise_rate) - 32'h1;
            end
            else
            begin
                st_d.code = st_q.code - 7'h01;
                st_d.cnt = step_cycles(decay_rate) - 32'h1;
            end
        end
        else if (st_q.cnt != 32'h0)
            st_d.cnt = st_q.cnt - 32'h1;
        st_d.current = code_to_ua(st_d.code, SQUARE_LAW);
        st_d.law_valid = !LAW_SELECT;
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st_q.fade_rates <= FADE_RATES_RESET;
            st_q.peak <= PEAK_CODE_RESET;
            st_q.code <= 7'h00;
            st_q.cnt <= 32'h0;
            st_q.rdata <= 8'h00;
            st_q.current <= 15'h0000;
            st_q.law_valid <= 1'b0;
        end
        else
            st_q <= st_d;
    end

    assign REG_RDATA = st_q.rdata;
    assign CUR_CODE = st_q.code;
    assign CURRENT_UA = st_q.current;
    assign LAW_VALID = st_q.law_valid;
    assign RAMP_BUSY = st_q.code != target;

    sequence s_step_due;
        st_q.cnt == 32'h0 && st_q.code != target;
    endsequence

    property p_unit_step;
        @(posedge CLK) disable iff (!RST_N)
        $changed(st_q.code) |->
            (st_q.code == $past(st_q.code) + 7'h01 ||
             st_q.code == $past(st_q.code) - 7'h01) && $past(st_q.cnt) == 0;
    endproperty
    a_unit_step: assert property (p_unit_step)
        else $error("Current code moved other than one step at a due time.");

    property p_rise;
        @(posedge CLK) disable iff (!RST_N)
        s_step_due and (BL_ON && st_q.code < st_q.peak) |=>
            st_q.code == $past(st_q.code) + 7'h01;
    endproperty
    a_rise: assert property (p_rise)
        else $error("Code did not rise toward the peak when on.");

    property p_decay;
        @(posedge CLK) disable iff (!RST_N)
        s_step_due and (!BL_ON) |=> st_q.code == $past(st_q.code) - 7'h01;
    endproperty
    a_decay: assert property (p_decay)
        else $error("Code did not fall when the backlight is off.");

    property p_interval;
        @(posedge CLK) disable iff (!RST_N)
        s_step_due and (st_q.code < target) |=>
            st_q.cnt == step_cycles($past(rise_rate)) - 32'h1;
    endproperty
    a_interval: assert property (p_interval)
        else $error("Step interval does not match the rise rate code.");

    property p_fast;
        @(posedge CLK) disable iff (!RST_N)
        s_step_due and (rise_rate == RATE_DISABLED && st_q.code < target)
            |=> st_q.cnt == FADE_UNIT_CYCLES_P - 1;
    endproperty
    a_fast: assert property (p_fast)
        else $error("Disabled fade does not use the fast ramp interval.");

    property p_hold;
        @(posedge CLK) disable iff (!RST_N)
        st_q.cnt != 32'h0 |=> $stable(st_q.code) &&
            st_q.cnt == $past(st_q.cnt) - 32'h1;
    endproperty
    a_hold: assert property (p_hold)
        else $error("Code moved or counter stalled within an interval.");

    property p_reserved;
        @(posedge CLK) disable iff (!RST_N)
        REG_RD && REG_ADDR == PEAK_CURRENT_OFFSET |=>
            REG_RDATA == {1'b0, $past(st_q.peak)};
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("Peak register read wrong or reserved bit set.");

    property p_map;
        @(posedge CLK) disable iff (!RST_N)
        (st_q.code == 7'h00 |-> CURRENT_UA == 15'h0000) and
        (st_q.code == TOP_CODE |-> CURRENT_UA == 15'(FULL_SCALE_UA));
    endproperty
    a_map: assert property (p_map)
        else $error("Current end points of the law mapping are wrong.");

    property p_law;
        @(posedge CLK) disable iff (!RST_N)
        LAW_SELECT |=> !LAW_VALID;
    endproperty
    a_law: assert property (p_law)
        else $error("Law mapping flagged valid with law select set.");

endmodule : backlight_fade_and_peak_current

// ==== testbench/host_model.sv ====
// Host model that drives the register port of the backlight block.
`timescale 1ns/1ps
module host_model
(
    // Clock.
    input wire logic CLK,
    // Register port.
    output logic [7:0] REG_ADDR,
    output logic REG_WR,
    output logic REG_RD,
    output logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA
);
    initial
    begin
        REG_ADDR = 8'h00;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_WDATA = 8'h00;
    end
    // One byte access; released write data shows the inverse value.
    task xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
              output logic [7:0] q);
    begin
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = wr;
        REG_RD = !wr;
        @(posedge CLK);
        #1;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_WDATA = ~d;
        @(posedge CLK);
        #1;
        q = REG_RDATA;
    end
    endtask : xfer
endmodule : host_model

// ==== testbench/backlight_fade_and_peak_current_tb.sv ====
// Self-checking bench for the backlight fade and peak current block.
`timescale 1ns/1ps
module backlight_fade_and_peak_current_tb;
    import backlight_fade_pkg::*;
    logic CLK, RST_N, BL_ON, LAW_SELECT, SQUARE_LAW, REG_WR, REG_RD;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, q;
    logic [6:0] CUR_CODE;
    logic [14:0] CURRENT_UA;
    logic LAW_VALID, RAMP_BUSY;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int g;
    backlight_fade_and_peak_current #(.FADE_UNIT_CYCLES_P(4))
        backlight_fade_and_peak_current_i (.CLK(CLK), .RST_N(RST_N),
        .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .BL_ON(BL_ON),
        .LAW_SELECT(LAW_SELECT), .SQUARE_LAW(SQUARE_LAW),
        .CUR_CODE(CUR_CODE), .CURRENT_UA(CURRENT_UA),
        .LAW_VALID(LAW_VALID), .RAMP_BUSY(RAMP_BUSY));
    host_model host_model_i (.CLK(CLK), .REG_ADDR(REG_ADDR),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA));
    initial
    begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            give_verdict();
        end
    end
    task give_verdict;
    begin
        $display("Counts: %0d checks, %0d mismatches", check_count,
                 mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask : give_verdict
    task chk(input string n, input logic [14:0] e, input logic [14:0] s);
    begin
        check_count++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %0d seen %0d", n, e, s);
        end
    end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        host_model_i.xfer(1'b1, a, d, q);
    endtask : wr
    task rd(input logic [7:0] a);
        host_model_i.xfer(1'b0, a, 8'h00, q);
    endtask : rd
    task tick;
        repeat (2) @(posedge CLK);
        #1;
    endtask : tick
    // Counts edges until the current code next moves.
    task gap;
        logic [6:0] c;
        c = CUR_CODE;
        g = 0;
        do
        begin
            @(posedge CLK);
            #1;
            g++;
        end while (CUR_CODE === c && g < 400);
    endtask : gap
    task t_regs;
        rd(FADE_RATES_OFFSET);
        chk("rates reset", 15'h0000, {7'h00, q});
        wr(PEAK_CURRENT_OFFSET, 8'hff);
        rd(PEAK_CURRENT_OFFSET);
        chk("peak reg", 15'h007f, {7'h00, q});
        wr(FADE_RATES_OFFSET, 8'h5a);
        rd(FADE_RATES_OFFSET);
        chk("rates reg", 15'h005a, {7'h00, q});
        rd(8'h10);
        chk("unmapped", 15'h0000, {7'h00, q});
        $display("TEST regs done");
    endtask : t_regs
    // Ramps up to code 2 and back, timing the second step each way.
    task ramp(input string n, input logic [7:0] r, input int up, dn);
        wr(FADE_RATES_OFFSET, r);
        wr(PEAK_CURRENT_OFFSET, 8'h02);
        BL_ON = 1'b1;
        gap();
        chk("rise busy", 15'h0001, {14'h0000, RAMP_BUSY});
        gap();
        chk("rise step", 15'(up), 15'(g));
        chk("peak code", 15'h0002, {8'h00, CUR_CODE});
        chk("peak idle", 15'h0000, {14'h0000, RAMP_BUSY});
        chk("current", 15'h01d8, CURRENT_UA);
        BL_ON = 1'b0;
        gap();
        chk("decay busy", 15'h0001, {14'h0000, RAMP_BUSY});
        gap();
        chk("decay step", 15'(dn), 15'(g));
        chk("off code", 15'h0000, {8'h00, CUR_CODE});
        chk("off idle", 15'h0000, {14'h0000, RAMP_BUSY});
        $display("TEST %s done", n);
    endtask : ramp
    task t_law;
        wr(FADE_RATES_OFFSET, 8'h00);
        wr(PEAK_CURRENT_OFFSET, 8'h7f);
        BL_ON = 1'b1;
        // The interval left over from the previous decay delays the rise.
        for (int i = 0; i < 1000 && CUR_CODE !== TOP_CODE; i++)
        begin
            @(posedge CLK);
            #1;
        end
        tick();
        chk("top linear", 15'h7530, CURRENT_UA);
        SQUARE_LAW = 1'b1;
        tick();
        chk("top square", 15'h7530, CURRENT_UA);
        chk("law valid", 15'h0001, {14'h0000, LAW_VALID});
        LAW_SELECT = 1'b1;
        tick();
        chk("law invalid", 15'h0000, {14'h0000, LAW_VALID});
        LAW_SELECT = 1'b0;
        wr(PEAK_CURRENT_OFFSET, 8'h01);
        for (int i = 0; i < 1000 && CUR_CODE !== 7'h01; i++)
        begin
            @(posedge CLK);
            #1;
        end
        tick();
        chk("one square", 15'h0001, CURRENT_UA);
        SQUARE_LAW = 1'b0;
        tick();
        chk("one linear", 15'h00ec, CURRENT_UA);
        $display("TEST law done");
    endtask : t_law
    initial
    begin
        RST_N = 1'b0;
        BL_ON = 1'b0;
        LAW_SELECT = 1'b0;
        SQUARE_LAW = 1'b0;
        repeat (3) @(posedge CLK);
        #1;
        RST_N = 1'b1;
        t_regs();
        ramp("fast", 8'h00, 4, 4);
        ramp("timed", 8'h21, 12, 24);
        ramp("coarse", 8'hfb, 140, 220);
        t_law();
        give_verdict();
    end
endmodule : backlight_fade_and_peak_current_tb
